// ### lpbr_merge.v
// low-power brown-out reset merge: gating, OR and shared brown-out flag
//
// Contract
// - hold reset while enabled monitor reports low
// - monitor reset updates the brown-out flag
// - one shared flag for both sources
// - monitor enabled only by configuration bit
// - erased configuration means monitor disabled
// - combined reset is OR of both
// - combined reset to status register, power control
`timescale 1ns/1ns
`include "lpbr_defines.vh"

module lpbr_merge (
  // clock and reset
  input  wire                      clock_i,
  input  wire                      reset_i,
  // configuration word and erased indication
  input  wire [`LPBR_CFG_W-1:0]    cfg_word_i,
  input  wire                      cfg_erased_i,
  // analog and main detector requests
  input  wire                      low_power_supply_monitor_low_i,
  input  wire                      brownout_reset_main_i,
  // software write of the shared flag (acknowledge)
  input  wire                      flag_write_i,
  input  wire                      flag_wdata_i,
  // outputs
  output wire                      brownout_reset_o,
  output wire                      power_ctrl_reset_o,
  output wire                      brownout_flag_n_o,
  output wire                      monitor_enabled_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state codes: one-hot, one bit per state
  localparam ST_W    = 3;
  localparam ST_SYS  = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_HOLD = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // monitor enable decode; an erased part overrides the word contents
  function cfg_monitor_on;
    input [`LPBR_CFG_W-1:0] word;
    input                   erased;
    begin
      if (erased) begin
        cfg_monitor_on = `LPBR_MON_OFF;
      end else begin
        cfg_monitor_on = (word[`LPBR_CFG_EN_BIT] == `LPBR_CFG_EN_ON);
      end
    end
  endfunction

  // gate the analog low indication with the decoded enable
  function monitor_request;
    input enabled;
    input supply_low;
    begin
      monitor_request = enabled & supply_low;
    end
  endfunction

  // merge of the two reset sources into the combined request
  function merge_requests;
    input monitor_rq;
    input main_rq;
    begin
      merge_requests = monitor_rq | main_rq;
    end
  endfunction

  // next state: hold while either source requests
  function [ST_W-1:0] state_next;
    input [ST_W-1:0] state;
    input            req;
    begin
      case (state)
        ST_SYS: begin
          state_next = req ? ST_HOLD : ST_RUN;
        end
        ST_RUN: begin
          state_next = req ? ST_HOLD : ST_RUN;
        end
        ST_HOLD: begin
          // no minimum hold; release follows the last withdrawal
          state_next = req ? ST_HOLD : ST_RUN;
        end
        default: begin
          // an illegal code recovers within one cycle
          state_next = req ? ST_HOLD : ST_RUN;
        end
      endcase
    end
  endfunction

  // reset outputs are asserted in every state but run
  function state_asserts_reset;
    input [ST_W-1:0] state;
    begin
      case (state)
        ST_SYS: begin
          state_asserts_reset = 1'h1;
        end
        ST_RUN: begin
          state_asserts_reset = 1'h0;
        end
        ST_HOLD: begin
          state_asserts_reset = 1'h1;
        end
        default: begin
          // safe side: an illegal code keeps the device in reset
          state_asserts_reset = 1'h1;
        end
      endcase
    end
  endfunction

  // shared flag next value; a brown-out beats a same-cycle write
  function flag_next;
    input cur_n;
    input brown;
    input wr;
    input wdata;
    begin
      if (brown) begin
        flag_next = `LPBR_FLAG_BROWN;
      end else if (wr) begin
        flag_next = wdata;
      end else begin
        flag_next = cur_n;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request gating
  wire                 monitor_en;
  wire                 monitor_req;
  wire                 combined;

  // state register
  reg  [ST_W-1:0]      state_q;
  reg  [ST_W-1:0]      state_d;

  // output registers
  reg                  brownout_reset_q;
  reg                  brownout_reset_d;
  reg                  power_ctrl_reset_q;
  reg                  power_ctrl_reset_d;
  reg                  brownout_flag_n_q;
  reg                  brownout_flag_n_d;
  reg                  monitor_enabled_q;
  reg                  monitor_enabled_d;

  ////////////////////////////////////////////////////////////////////////////
  // the enable comes from the configuration word and the erased indication alone, never software
  assign monitor_en  = cfg_monitor_on(cfg_word_i, cfg_erased_i);
  assign monitor_req = monitor_request(monitor_en,
                                       low_power_supply_monitor_low_i);
  // pure OR: stays asserted while either source still requests
  assign combined    = merge_requests(monitor_req,
                                      brownout_reset_main_i);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always @* begin
    state_d = state_next(state_q, combined);
  end

  // next values of the reset outputs, one cycle behind the requests
  always @* begin
    brownout_reset_d   = state_asserts_reset(state_d);
    power_ctrl_reset_d = state_asserts_reset(state_d);
  end

  // the enable indication follows the decode with one cycle of delay
  always @* begin
    monitor_enabled_d = monitor_en;
  end

  // either source lowers the one shared flag
  always @* begin
    brownout_flag_n_d = flag_next(brownout_flag_n_q, combined,
                                  flag_write_i, flag_wdata_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= ST_SYS;
    end else begin
      state_q <= state_d;
    end
  end

  // combined reset, to the status register and to power control
  always @(posedge clock_i) begin
    if (reset_i) begin
      brownout_reset_q   <= `LPBR_RST_OUT_RST;
      power_ctrl_reset_q <= `LPBR_RST_OUT_RST;
    end else begin
      brownout_reset_q   <= brownout_reset_d;
      power_ctrl_reset_q <= power_ctrl_reset_d;
    end
  end

  // monitor enable indication
  always @(posedge clock_i) begin
    if (reset_i) begin
      monitor_enabled_q <= `LPBR_MON_EN_RST;
    end else begin
      monitor_enabled_q <= monitor_enabled_d;
    end
  end

  // shared flag: software may change it only while no brown-out is active
  always @(posedge clock_i) begin
    if (reset_i) begin
      brownout_flag_n_q <= `LPBR_FLAG_RST;
    end else begin
      brownout_flag_n_q <= brownout_flag_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // every output comes straight from its register
  assign brownout_reset_o   = brownout_reset_q;
  assign power_ctrl_reset_o = power_ctrl_reset_q;
  assign brownout_flag_n_o  = brownout_flag_n_q;
  assign monitor_enabled_o  = monitor_enabled_q;

endmodule

// ### lpbr_defines.vh
// constants for the low-power brown-out reset merge block
`ifndef LPBR_DEFINES_VH
`define LPBR_DEFINES_VH

// erased configuration word reads as all ones; enable bit is active low
`define LPBR_CFG_W        14
`define LPBR_CFG_EN_BIT   11
`define LPBR_CFG_EN_ON    1'h0
`define LPBR_MON_OFF      1'h0
// power-control status flag: low means a brown-out reset occurred
`define LPBR_FLAG_RST     1'h1
`define LPBR_FLAG_BROWN   1'h0
// reset values of the combined reset outputs and the enable indication
`define LPBR_RST_OUT_RST  1'h1
`define LPBR_MON_EN_RST   1'h0

`endif

// ### lpbr_det.sv
// far-side model: supply-low and main detector levels
`timescale 1ns/1ns
module lpbr_det(input wire [1:0] req_i, output wire low_o, main_o);
  // both detectors give levels that stand until they are withdrawn
  assign {low_o,main_o}=req_i;
endmodule

// ### lpbr_properties.sv
// checker for the brown-out reset merge
`timescale 1ns/1ns
`include "lpbr_defines.vh"
module lpbr_properties (
  input wire                   clock_i,
  input wire                   reset_i,
  input wire [`LPBR_CFG_W-1:0] cfg_word_i,
  input wire                   cfg_erased_i,
  input wire                   low_power_supply_monitor_low_i,
  input wire                   brownout_reset_main_i,
  input wire                   flag_write_i,
  input wire                   flag_wdata_i,
  input wire                   brownout_reset_o,
  input wire                   power_ctrl_reset_o,
  input wire                   brownout_flag_n_o,
  input wire                   monitor_enabled_o
);
  // reference decode from the constants, independent of the design
  wire n = !cfg_erased_i &&
           (cfg_word_i[`LPBR_CFG_EN_BIT] == `LPBR_CFG_EN_ON);
  wire l = n && low_power_supply_monitor_low_i;
  wire a = l || brownout_reset_main_i;
  wire r = brownout_reset_o;
  wire f = brownout_flag_n_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_low_hold: assert property (l |=> r)
    else $error("reset not held while monitor reports low");
  a_flag_low: assert property (l |=> f == `LPBR_FLAG_BROWN)
    else $error("monitor reset did not mark the flag");
  a_flag_main: assert property (
    brownout_reset_main_i |=> f == `LPBR_FLAG_BROWN)
    else $error("main reset did not mark the shared flag");
  a_cfg_gate: assert property (
    1'h1 |=> monitor_enabled_o == $past(n))
    else $error("enable does not follow the configuration bit");
  a_erase_off: assert property (
    cfg_erased_i |=> !monitor_enabled_o)
    else $error("monitor enabled on an erased part");
  a_or_form: assert property (1'h1 |=> r == $past(a))
    else $error("combined reset is not the OR of both sources");
  a_pc_route: assert property (power_ctrl_reset_o == r)
    else $error("power control reset differs from combined reset");
  a_both_gone: assert property (
    $fell(r) |-> !$past(l) && !$past(brownout_reset_main_i))
    else $error("reset released while a source still requests");
  a_flag_write: assert property (
    !a && flag_write_i |=> f == $past(flag_wdata_i))
    else $error("flag write not taken");
  a_flag_keep: assert property (
    !a && !flag_write_i |=> $stable(f))
    else $error("flag changed without a cause");
  a_reset_vals: assert property (
    disable iff (1'h0) reset_i |=> r && power_ctrl_reset_o &&
    f == `LPBR_FLAG_RST && !monitor_enabled_o)
    else $error("wrong output values under system reset");
  cover property (l);
  cover property ($fell(r));
  cover property (!f ##1 f);
  cover property (!a && flag_write_i ##1 f);
endmodule
bind lpbr_merge lpbr_properties lpbr_properties_i(.*);

// ### test_lpbr_merge.sv
// bench: random config and detector levels, queued expectations
`timescale 1ns/1ns
`include "lpbr_defines.vh"
module test_lpbr_merge;
  reg                   clock_i = 1'h0;
  reg                   reset_i = 1'h1;
  reg                   er = 1'h0;
  reg                   fw = 1'h0;
  reg                   fd = 1'h0;
  reg                   en;
  reg                   e;
  reg                   ef = `LPBR_FLAG_RST;
  reg [`LPBR_CFG_W-1:0] cw = {`LPBR_CFG_W{1'h0}};
  reg [1:0]             rq = 2'h0;
  reg [3:0]             q[$];
  reg [3:0]             exp_v;
  wire                  lo, mn, br, pc, fl, me;
  integer               seed = 7589;
  integer               num_errors = 0;
  integer               checks_done = 0;
  integer               i;
  integer               rv;
  lpbr_det lpbr_det_i(.req_i(rq),.low_o(lo),.main_o(mn));
  lpbr_merge lpbr_merge_i(.clock_i(clock_i),.reset_i(reset_i),.cfg_word_i(cw),
    .cfg_erased_i(er),.low_power_supply_monitor_low_i(lo),
    .brownout_reset_main_i(mn),.flag_write_i(fw),.flag_wdata_i(fd),
    .brownout_reset_o(br),.power_ctrl_reset_o(pc),
    .brownout_flag_n_o(fl),.monitor_enabled_o(me));
  initial forever #50 clock_i=~clock_i;
  task end_sim;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  // one cycle of stimulus; the expectation follows the rules
  task drive_cycle;
    input rst;
    begin
      reset_i = rst;
      rv = $random(seed);
      {er, fw, fd} = rv[2:0];
      rv = $random(seed);
      cw = rv[`LPBR_CFG_W-1:0];
      rv = $random(seed);
      rq = rv[1:0];
      en = !er && (cw[`LPBR_CFG_EN_BIT] == `LPBR_CFG_EN_ON);
      e = (en && rq[1]) || rq[0];
      if (rst) begin
        ef = `LPBR_FLAG_RST;
        q.push_back({1'h1, 1'h1, 1'h0, `LPBR_FLAG_RST});
      end else begin
        if (e) begin
          ef = `LPBR_FLAG_BROWN;
        end else if (fw) begin
          ef = fd;
        end
        q.push_back({e, e, en, ef});
      end
      @(negedge clock_i);
    end
  endtask
  // compare the oldest expectation once the outputs have settled
  always @(posedge clock_i) begin
    if (q.size() > 0) begin
      #1;
      exp_v = q.pop_front();
      checks_done = checks_done + 1;
      if ({br, pc, me} !== exp_v[3:1]) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t reset or enable mismatch", $time);
      end
      checks_done = checks_done + 1;
      if (fl !== exp_v[0]) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t shared flag mismatch", $time);
      end
    end
  end
  initial begin
    repeat (10) @(negedge clock_i);
    for (i = 0; i < 200; i = i + 1) begin
      drive_cycle(1'h0);
    end
    $display("random test done");
    for (i = 0; i < 3; i = i + 1) begin
      drive_cycle(1'h1);
    end
    for (i = 0; i < 200; i = i + 1) begin
      drive_cycle(1'h0);
    end
    $display("reset test done");
    if (q.size() != 0) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t expectations left unchecked", $time);
    end
    end_sim;
  end
endmodule
